// ---- src/acq_trig_defs.vh ----
`ifndef ACQ_TRIG_DEFS_VH
`define ACQ_TRIG_DEFS_VH

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_FRAME_COUNT 12'h004
`define REG_CMD 12'h008
`define REG_STATUS 12'h00C

// Control register fields
`define CTRL_TRIG_MODE 0
`define CTRL_SRC_LINE 1
`define CTRL_FALLING 2
`define CTRL_SEL_ACQ 3
`define CTRL_CONTINUOUS 4
`define CTRL_WIDTH 5
`define CTRL_RESET 5'h08

// Command register fields, write-one pulses
`define CMD_SW_TRIG 0
`define CMD_ACQ_START 1
`define CMD_ACQ_STOP 2

// Status register fields
`define STAT_WAIT_ACQ 0
`define STAT_WAIT_FRAME 1
`define STAT_ARMED 2
`define STAT_COUNT_LSB 8

`define FRAME_COUNT_RESET 8'h01
`define FRAME_COUNT_MIN 8'h01

`endif

// ---- src/edge_sync.v ----
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser plus edge detector, one pulse per rising edge, or per falling edge when falling is set
module edge_sync
(
    input wire clk_sys,
    input wire rst,
    input wire sig_in,
    input wire falling,
    output reg edge_pulse
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            edge_pulse <= 1'b0;
        end
        else
        begin
            meta_q <= sig_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
            edge_pulse <= falling ? (prev_q & ~sync_q) : (~prev_q & sync_q);
        end
    end
endmodule // edge_sync

`default_nettype wire

// ---- src/acq_start_trig_ctrl.v ----
// Notes on behaviour
// - Each software trigger command with selector on acquisition start is one trigger.
// - Trigger mode on: start waiting for acquisition start, ignore frame triggers.
// - Acquisition start trigger moves the state to waiting for frame start.
// - Count accepted frame triggers; return to waiting when count reaches setting. Code returns only in trigger mode on, else stays waiting for frame start.
// - Each further valid acquisition start trigger re-enters waiting for frame start.
// - Line source uses external input line 1 as acquisition start trigger.
// - Line source edge is rising or falling as selected by polarity.
// - Frame count setting lies in 1 to 255; counter is eight bits.
// - Trigger mode off: acquisition start triggers are made internally.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "acq_trig_defs.vh"

module acq_start_trig_ctrl
#(
    parameter CNT_W = 8
)
(
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    input wire ext_acq_start_trig_in,
    input wire frame_start_trig,
    output wire frame_trig_accept,
    output wire wait_frame_start,
    output wire acq_start_pulse
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT_ACQ = 3'b010;
    localparam ST_WAIT_FRAME = 3'b100;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [`CTRL_WIDTH-1:0] ctrl_q;
    reg [CNT_W-1:0] frame_count_q;
    reg [CNT_W-1:0] frames_q;
    reg [CNT_W-1:0] frames_d;
    reg sw_trig_q;
    reg start_cmd_q;
    reg stop_cmd_q;
    wire line_pulse;
    wire trig_event;
    wire wr_en;
    wire rd_en;
    wire wr_low;
    wire sel_ctrl;
    wire sel_count;
    wire sel_cmd;
    wire sel_status;
    wire acq_taken;
    wire [CNT_W-1:0] count_wr;

    function is_reg;
        input [11:0] a;
        begin
            is_reg = (a == `REG_CTRL) || (a == `REG_FRAME_COUNT) || (a == `REG_CMD) || (a == `REG_STATUS);
        end
    endfunction

    // Zero is not a legal frame count, so it is stored as one
    function [CNT_W-1:0] clamp_count;
        input [CNT_W-1:0] v;
        begin
            if (v < `FRAME_COUNT_MIN)
                clamp_count = `FRAME_COUNT_MIN;
            else
                clamp_count = v;
        end
    endfunction

    // Status word: waiting flags, armed flag, frames counted so far
    function [31:0] status_word;
        input [2:0] cur_state;
        input [CNT_W-1:0] frame_cnt;
        begin
            status_word = 32'h00000000;
            status_word[`STAT_WAIT_ACQ] = cur_state[1];
            status_word[`STAT_WAIT_FRAME] = cur_state[2];
            status_word[`STAT_ARMED] = ~cur_state[0];
            status_word[`STAT_COUNT_LSB +: CNT_W] = frame_cnt;
        end
    endfunction

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~is_reg(paddr);
    assign wr_en = psel & penable & pwrite & is_reg(paddr);
    assign rd_en = psel & ~penable & ~pwrite;
    assign wr_low = wr_en & pstrb[0];
    assign sel_ctrl = (paddr == `REG_CTRL);
    assign sel_count = (paddr == `REG_FRAME_COUNT);
    assign sel_cmd = (paddr == `REG_CMD);
    assign sel_status = (paddr == `REG_STATUS);
    assign count_wr = clamp_count(pwdata[CNT_W-1:0]);

    edge_sync u_edge_sync
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .sig_in(ext_acq_start_trig_in),
        .falling(ctrl_q[`CTRL_FALLING]),
        .edge_pulse(line_pulse)
    );

    // Trigger source mux; internal trigger when trigger mode is off
    assign trig_event = ~ctrl_q[`CTRL_TRIG_MODE] ? 1'b1 :
        (ctrl_q[`CTRL_SRC_LINE] ? line_pulse : sw_trig_q);

    assign wait_frame_start = state_q[2];
    assign frame_trig_accept = state_q[2] & frame_start_trig;
    // A stop in the same cycle wins, so no start is reported then
    assign acq_taken = state_q[1] & trig_event & ~stop_cmd_q;
    assign acq_start_pulse = acq_taken;

    always @*
    begin
        state_d = state_q;
        frames_d = frames_q;
        case (state_q)
            ST_IDLE:
            begin
                frames_d = {CNT_W{1'b0}};
                if (start_cmd_q)
                    state_d = ST_WAIT_ACQ;
            end
            ST_WAIT_ACQ:
            begin
                frames_d = {CNT_W{1'b0}};
                if (stop_cmd_q)
                    state_d = ST_IDLE;
                else if (trig_event)
                    state_d = ST_WAIT_FRAME;
            end
            ST_WAIT_FRAME:
            begin
                if (stop_cmd_q)
                    state_d = ST_IDLE;
                else if (frame_start_trig)
                begin
                    frames_d = frames_q + 1'b1;
                    if (ctrl_q[`CTRL_TRIG_MODE] && (frames_d >= frame_count_q))
                    begin
                        state_d = ST_WAIT_ACQ;
                        frames_d = {CNT_W{1'b0}};
                    end
                end
            end
            default:
            begin
                state_d = ST_IDLE;
                frames_d = {CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            frames_q <= {CNT_W{1'b0}};
            ctrl_q <= `CTRL_RESET;
            frame_count_q <= `FRAME_COUNT_RESET;
        end
        else
        begin
            state_q <= state_d;
            frames_q <= frames_d;
            if (wr_low && sel_ctrl)
                ctrl_q <= pwdata[`CTRL_WIDTH-1:0];
            if (wr_low && sel_count)
                frame_count_q <= count_wr;
        end
    end

    // Command bits live one cycle only, so a later write cannot replay them
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            sw_trig_q <= 1'b0;
            start_cmd_q <= 1'b0;
            stop_cmd_q <= 1'b0;
        end
        else if (wr_low && sel_cmd)
        begin
            sw_trig_q <= pwdata[`CMD_SW_TRIG] & ctrl_q[`CTRL_SEL_ACQ];
            start_cmd_q <= pwdata[`CMD_ACQ_START];
            stop_cmd_q <= pwdata[`CMD_ACQ_STOP];
        end
        else
        begin
            sw_trig_q <= 1'b0;
            start_cmd_q <= 1'b0;
            stop_cmd_q <= 1'b0;
        end
    end

    // Read data registered in setup cycle
    always @(posedge clk_sys)
    begin
        if (rst)
            prdata <= 32'h00000000;
        else if (rd_en)
        begin
            if (sel_ctrl)
                prdata <= {{(32-`CTRL_WIDTH){1'b0}}, ctrl_q};
            else if (sel_count)
                prdata <= {{(32-CNT_W){1'b0}}, frame_count_q};
            else if (sel_status)
                prdata <= status_word(state_q, frames_q);
            else
                prdata <= 32'h00000000;
        end
    end
endmodule // acq_start_trig_ctrl

`default_nettype wire

// ---- test/trig_ctrl_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module trig_ctrl_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic frame_start_trig,
    input wire logic frame_trig_accept,
    input wire logic wait_frame_start,
    input wire logic acq_start_pulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_take;
        wait_frame_start && frame_start_trig;
    endsequence
    a_frame_ignored: assert property (!wait_frame_start |-> !frame_trig_accept) else $error("idle accept");
    a_frame_taken: assert property (s_take |-> frame_trig_accept) else $error("frame lost");
    a_accept_cause: assert property (frame_trig_accept |-> frame_start_trig) else $error("no frame");
    a_start_enters: assert property (acq_start_pulse |=> wait_frame_start) else $error("no entry");
    a_pulse_single: assert property (acq_start_pulse |=> !acq_start_pulse) else $error("long pulse");
    a_no_double_start: assert property (wait_frame_start |-> !acq_start_pulse) else $error("late start");
    a_wait_leaves: assert property ($fell(wait_frame_start)
        |-> $past(frame_trig_accept) || $past(psel) || $past(psel, 2)) else $error("bad exit");
    a_ready_access: assert property (psel && penable |-> pready) else $error("no ready");
endmodule // trig_ctrl_asserts
bind acq_start_trig_ctrl trig_ctrl_asserts trig_ctrl_asserts_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pready(pready), .frame_start_trig(frame_start_trig), .frame_trig_accept(frame_trig_accept),
    .wait_frame_start(wait_frame_start), .acq_start_pulse(acq_start_pulse));
`default_nettype wire

// ---- test/trig_source.sv ----
`timescale 1ns/10ps
`default_nettype none
module trig_source (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic fr_req,
    input wire logic flip,
    output logic line,
    output logic frame_start_trig
);
    always @(posedge clk_sys)
    begin
        line <= rst ? 1'h0 : line ^ flip;
        frame_start_trig <= !rst && fr_req;
    end
endmodule // trig_source
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "acq_trig_defs.vh"
module testbench;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fr_req = 0, flip = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, err, line, fst, accept, wfs, asp;
    logic [3:0] strb = 4'hF;
    int fail_count = 0, total_checks = 0, st = 0, cnt = 0, fc = 1, seed = 93472, cyc = 0, pulses = 0, np = 0;
    always #50 clk_sys = ~clk_sys;
    acq_start_trig_ctrl acq_start_trig_ctrl_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .ext_acq_start_trig_in(line), .frame_start_trig(fst), .frame_trig_accept(accept),
        .wait_frame_start(wfs), .acq_start_pulse(asp));
    trig_source trig_source_i (.clk_sys(clk_sys), .rst(rst), .fr_req(fr_req), .flip(flip), .line(line),
        .frame_start_trig(fst));
    task check(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Idle cycle keeps a following setup off this time step
        @(posedge clk_sys);
    endtask
    task look;
        repeat (6) @(posedge clk_sys);
        check(wfs, st == 2);
        apb(1'h0, `REG_STATUS, 32'h0);
        check(rd, cnt * 256 + (st != 0 ? 4 : 0) + (st == 2 ? 2 : 0) + (st == 1 ? 1 : 0));
    endtask
    task tog;
        flip <= 1'h1;
        @(posedge clk_sys);
        flip <= 1'h0;
    endtask
    // Accept stands only while the partner holds its frame pulse
    task frame;
        fr_req <= 1'h1;
        @(posedge clk_sys);
        fr_req <= 1'h0;
        #1 check(accept, st == 2);
        @(posedge clk_sys);
        cnt += (st == 2);
        if (cnt == fc) st = 1;
        cnt %= fc;
    endtask
    // Start pulse counted mid-cycle, where it is settled
    always @(negedge clk_sys)
        if (asp === 1'h1) pulses++;
    always @(posedge clk_sys)
        if (++cyc > 3000)
        begin
            fail_count++;
            tally_and_finish();
        end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        apb(1'h0, `REG_FRAME_COUNT, 32'h0);
        check(rd, 32'h1);
        apb(1'h0, 12'h010, 32'h0);
        check(err, 1'h1);
        strb <= 4'h0;
        apb(1'h1, `REG_FRAME_COUNT, 32'h7);
        strb <= 4'hF;
        apb(1'h0, `REG_FRAME_COUNT, 32'h0);
        check(rd, 32'h1);
        fc = 1 + {$random(seed)} % 3;
        apb(1'h1, `REG_FRAME_COUNT, fc);
        apb(1'h0, `REG_FRAME_COUNT, 32'h0);
        check(rd, fc);
        apb(1'h1, `REG_CTRL, 32'h11);
        apb(1'h0, `REG_CTRL, 32'h0);
        check(rd, 32'h11);
        apb(1'h1, `REG_CMD, 32'h2);
        st = 1;
        apb(1'h1, `REG_CMD, 32'h1);
        look();
        apb(1'h1, `REG_CTRL, 32'h19);
        frame();
        repeat (2)
        begin
            apb(1'h1, `REG_CMD, 32'h1);
            st = 2;
            np++;
            look();
            repeat (fc) frame();
            look();
        end
        for (int p = 0; p < 2; p++)
        begin
            apb(1'h1, `REG_CMD, 32'h4);
            apb(1'h1, `REG_CTRL, 32'h1B | p << 2);
            st = 0;
            if (line === p[0]) tog();
            look();
            apb(1'h1, `REG_CMD, 32'h2);
            st = 1;
            tog();
            look();
            tog();
            st = 2;
            np++;
            look();
        end
        apb(1'h1, `REG_CMD, 32'h4);
        st = 0;
        apb(1'h1, `REG_CTRL, 32'h18);
        apb(1'h1, `REG_CMD, 32'h2);
        st = 2;
        np++;
        look();
        check(pulses, np);
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
